// ---- rtl/sel_pkg.sv ----
// Shared constants and types of the dual master selector control.
// Assumes a single 25 MHz system clock and open-drain pins resolved
// outside the design from the output enables.
package sel_pkg;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 40;
  // Half period of the recovery clock, 100 kHz overall
  localparam int REC_HALF_NS   = 5000;
  localparam int REC_HALF_CYC  =
    (REC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Nine clocks, then one more clock with SDA released as the NACK
  localparam int REC_PULSES    = 10;
  localparam int REC_STEPS     = 2 * REC_PULSES + 3;
  localparam int HOLD_OFF      = 3;

  // ***********************************************************
  // Reset values and fixed address bits
  // ***********************************************************
  localparam logic [1:0] OWNER_NONE = 2'h0;
  localparam logic [1:0] OWNER_A    = 2'h1;
  localparam logic [1:0] OWNER_B    = 2'h2;
  // Upper address bits, arbitrary value
  localparam logic [2:0] ADDR_FIXED = 3'h7;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [1:0] {
    VAR_CH0_AT_START   = 2'h0,
    VAR_CH0_AFTER_STOP = 2'h1,
    VAR_NONE_AT_START  = 2'h2
  } variant_t;

  typedef enum logic [2:0] {
    ST_WAIT_STOP = 3'h1,
    ST_RUN       = 3'h2,
    ST_RECOVER   = 3'h4
  } state_t;

  typedef struct packed {
    logic fwd_en;
    logic mask_lost;
    logic mask_done;
    logic mask_busy;
  } irq_cfg_t;

  typedef struct packed {
    logic lost;
    logic done;
    logic busy;
  } irq_flags_t;

endpackage

// ---- rtl/master_selector.sv ----
// Control logic of a 2-to-1 master selector: ownership, recovery
// sequence, traffic sensor and upstream interrupts.
// Assumes a command decoder on I_CLK_SYS that turns upstream writes
// into request, drop and clear pulses and holds the configuration.
`timescale 1ns/1ps
module master_selector
  import sel_pkg::*;
#(
  parameter variant_t VARIANT = VAR_CH0_AT_START
)
(
  input  wire logic           I_CLK_SYS,              // System clock
  input  wire logic           I_RST_N,                // Reset pin, low
  input  wire logic           I_POR_N,                // Power-on reset, low
  input  wire logic [3:0]     I_ADDR,                 // Address straps
  input  wire logic [1:0]     I_UP_SCL,               // Upstream SCL in
  input  wire logic [1:0]     I_UP_SDA,               // Upstream SDA in
  output logic      [1:0]     O_UP_SCL,               // Upstream SCL out
  output logic      [1:0]     O_UP_SCL_OE,            // Upstream SCL drive
  output logic      [1:0]     O_UP_SDA,               // Upstream SDA out
  output logic      [1:0]     O_UP_SDA_OE,            // Upstream SDA drive
  input  wire logic           I_DN_SCL,               // Downstream SCL in
  input  wire logic           I_DN_SDA,               // Downstream SDA in
  output logic                O_DN_SCL,               // Downstream SCL out
  output logic                O_DN_SCL_OE,            // Downstream SCL drive
  output logic                O_DN_SDA,               // Downstream SDA out
  output logic                O_DN_SDA_OE,            // Downstream SDA drive
  input  wire logic           I_INT_IN_N,             // Downstream irq, low
  input  wire logic [1:0]     I_REQ,                  // Take bus pulse
  input  wire logic [1:0]     I_DROP,                 // Release bus pulse
  input  wire logic [1:0]     I_CLR_FLAGS,            // Clear flags pulse
  input  wire irq_cfg_t [1:0] I_CFG,                  // Per master irq cfg
  input  wire logic           I_RECOV_EN,             // Built-in recovery
  input  wire logic           I_SENSOR_DIS,           // Sensor irq off
  output logic                O_UPSTREAM_A_IRQ_OUT_N, // Master A irq, low
  output logic                O_UPSTREAM_B_IRQ_OUT_N, // Master B irq, low
  output logic      [1:0]     O_OWNERSHIP_LOST_FLAG,  // Sticky lost flags
  output logic      [1:0]     O_DONE_FLAG,            // Sticky done flags
  output logic      [1:0]     O_BUSY_FLAG,            // Sticky busy flags
  output logic      [1:0]     O_OWNER,                // Connected master
  output logic                O_RECOV_ACTIVE,         // Recovery running
  output logic      [6:0]     O_SLAVE_ADDR            // Own slave address
);

  // ***********************************************************
  // Reset and input synchronisers
  // ***********************************************************
  logic rst;
  assign rst = ~I_RST_N | ~I_POR_N;

  logic [10:0] raw;
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic [10:0] prev;
  assign raw = {I_ADDR, I_INT_IN_N, I_DN_SDA, I_DN_SCL, I_UP_SDA, I_UP_SCL};

  // 25 MHz sampling leaves wide margin over a 400 kHz bus
  // Runs through reset, so the straps are settled before release
  always_ff @(posedge I_CLK_SYS)
  begin
    sync1 <= raw;
    sync2 <= sync1;
  end

  // Idle-high history, so no false START or STOP right after reset
  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
      prev <= 11'h7ff;
    else
      prev <= sync2;
  end

  logic [1:0] up_scl;
  logic [1:0] up_sda;
  logic       dn_scl;
  logic       dn_sda;
  logic       int_n;
  assign up_scl = sync2[1:0];
  assign up_sda = sync2[3:2];
  assign dn_scl = sync2[4];
  assign dn_sda = sync2[5];
  assign int_n  = sync2[6];

  // ***********************************************************
  // Slave address
  // ***********************************************************
  // Straps are caught while reset is held, never between resets
  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
      O_SLAVE_ADDR <= {ADDR_FIXED, sync2[10:7]};
  end

  // ***********************************************************
  // START and STOP detection
  // ***********************************************************
  logic dn_start;
  logic dn_stop;
  logic a_stop;
  logic dn_busy;
  logic dn_idle;
  assign dn_start = prev[5] & ~dn_sda & dn_scl & prev[4];
  assign dn_stop  = ~prev[5] & dn_sda & dn_scl & prev[4];
  assign a_stop   = ~prev[2] & up_sda[0] & up_scl[0] & prev[0];

  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
      dn_busy <= 1'b0;
    else if (dn_start)
      dn_busy <= 1'b1;
    else if (dn_stop)
      dn_busy <= 1'b0;
  end

  assign dn_idle = ~dn_busy & dn_scl & dn_sda;

  // ***********************************************************
  // Ownership state machine
  // ***********************************************************
  localparam int DIV_W = $clog2(REC_HALF_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REC_HALF_CYC - 1);
  localparam logic [4:0] STEP_LAST = 5'(REC_STEPS - 1);
  localparam logic [4:0] STEP_STOP = 5'(2 * REC_PULSES);

  state_t           state;
  state_t           next_state;
  logic [1:0]       owner;
  logic [1:0]       next_owner;
  logic [1:0]       target;
  logic [1:0]       next_target;
  logic [4:0]       step;
  logic [4:0]       next_step;
  logic [DIV_W-1:0] div;
  logic             tick;
  logic [1:0]       req_sel;
  logic [1:0]       done_ev;
  logic [1:0]       busy_ev;
  logic [1:0]       lost_ev;

  assign tick    = (state == ST_RECOVER) && (div == DIV_LAST);
  // Same pulses from either side; A wins a tie
  assign req_sel = I_REQ[0] ? OWNER_A : OWNER_B;

  always_comb
  begin
    next_state  = state;
    next_owner  = owner;
    next_target = target;
    next_step   = step;
    done_ev     = 2'h0;
    busy_ev     = 2'h0;
    if (|I_REQ)
    begin
      if (I_RECOV_EN)
      begin
        next_state  = ST_RECOVER;
        next_owner  = OWNER_NONE;
        next_target = req_sel;
        next_step   = 5'h0;
      end
      else
      begin
        next_state  = ST_RUN;
        next_owner  = req_sel;
        next_target = req_sel;
        if (req_sel != owner && !dn_idle && !I_SENSOR_DIS)
          busy_ev = req_sel;
      end
    end
    else if (|(I_DROP & (owner | target)))
    begin
      next_state  = ST_RUN;
      next_owner  = OWNER_NONE;
      next_target = OWNER_NONE;
    end
    else
    begin
      case (state)
        ST_WAIT_STOP:
        begin
          if (a_stop)
          begin
            next_state  = ST_RUN;
            next_owner  = OWNER_A;
            next_target = OWNER_A;
          end
        end
        ST_RUN:
        begin
        end
        ST_RECOVER:
        begin
          if (tick)
          begin
            next_step = step + 5'h1;
            if (step == STEP_LAST)
            begin
              next_state = ST_RUN;
              next_owner = target;
              done_ev    = target;
            end
          end
        end
        default:
        begin
          next_state = ST_RUN;
          next_owner = OWNER_NONE;
        end
      endcase
    end
  end

  assign lost_ev = owner & ~next_owner;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
    begin
      state <= (VARIANT == VAR_CH0_AFTER_STOP) ? ST_WAIT_STOP : ST_RUN;
      owner  <= (VARIANT == VAR_CH0_AT_START) ? OWNER_A : OWNER_NONE;
      target <= (VARIANT == VAR_CH0_AT_START) ? OWNER_A : OWNER_NONE;
      step   <= 5'h0;
    end
    else
    begin
      state  <= next_state;
      owner  <= next_owner;
      target <= next_target;
      step   <= next_step;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst || state != ST_RECOVER || |I_REQ || tick)
      div <= '0;
    else
      div <= div + DIV_W'(1);
  end

  // ***********************************************************
  // Pin drive
  // ***********************************************************
  logic                rec_scl_low;
  logic                rec_sda_low;
  logic [HOLD_OFF-1:0] scl_hist;
  logic [HOLD_OFF-1:0] sda_hist;
  // Even steps low, odd steps high, then STOP with SDA held low
  assign rec_scl_low = (state == ST_RECOVER) &&
                       (step < STEP_STOP ? ~step[0] : step == STEP_STOP);
  assign rec_sda_low = (state == ST_RECOVER) &&
                       (step == STEP_STOP || step == STEP_STOP + 5'h1);

  assign O_UP_SCL = 2'h0;
  assign O_UP_SDA = 2'h0;
  assign O_DN_SCL = 1'b0;
  assign O_DN_SDA = 1'b0;

  // Echo of our own downstream drive is held off for a few cycles,
  // else a released line would latch low through the loop
  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
    begin
      O_DN_SCL_OE <= 1'b0;
      O_DN_SDA_OE <= 1'b0;
      O_UP_SCL_OE <= 2'h0;
      O_UP_SDA_OE <= 2'h0;
      scl_hist    <= '0;
      sda_hist    <= '0;
    end
    else
    begin
      O_DN_SCL_OE <= rec_scl_low | |(owner & ~up_scl);
      O_DN_SDA_OE <= rec_sda_low | |(owner & ~up_sda);
      scl_hist    <= {scl_hist[HOLD_OFF-2:0], O_DN_SCL_OE};
      sda_hist    <= {sda_hist[HOLD_OFF-2:0], O_DN_SDA_OE};
      O_UP_SCL_OE <= owner & {2{~dn_scl & ~O_DN_SCL_OE & ~|scl_hist}};
      O_UP_SDA_OE <= owner & {2{~dn_sda & ~O_DN_SDA_OE & ~|sda_hist}};
    end
  end

  // ***********************************************************
  // Flags and upstream interrupts
  // ***********************************************************
  irq_flags_t [1:0] flags;
  logic       [1:0] irq;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
      flags <= '0;
    else
      for (int m = 0; m < 2; m++)
      begin
        flags[m].lost <= (flags[m].lost & ~I_CLR_FLAGS[m]) | lost_ev[m];
        flags[m].done <= (flags[m].done & ~I_CLR_FLAGS[m]) | done_ev[m];
        flags[m].busy <= (flags[m].busy & ~I_CLR_FLAGS[m]) | busy_ev[m];
      end
  end

  always_comb
  begin
    for (int m = 0; m < 2; m++)
      irq[m] = (I_CFG[m].fwd_en & ~int_n) |
               (flags[m].lost & ~I_CFG[m].mask_lost) |
               (flags[m].done & ~I_CFG[m].mask_done) |
               (flags[m].busy & ~I_CFG[m].mask_busy);
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (rst)
    begin
      O_UPSTREAM_A_IRQ_OUT_N <= 1'b1;
      O_UPSTREAM_B_IRQ_OUT_N <= 1'b1;
    end
    else
    begin
      O_UPSTREAM_A_IRQ_OUT_N <= ~irq[0];
      O_UPSTREAM_B_IRQ_OUT_N <= ~irq[1];
    end
  end

  always_comb
  begin
    for (int m = 0; m < 2; m++)
    begin
      O_OWNERSHIP_LOST_FLAG[m] = flags[m].lost;
      O_DONE_FLAG[m]           = flags[m].done;
      O_BUSY_FLAG[m]           = flags[m].busy;
    end
  end

  assign O_OWNER        = owner;
  assign O_RECOV_ACTIVE = (state == ST_RECOVER);

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (rst);

  AST_START_OWNER: assert property (
    $past(rst) |-> owner ==
      ((VARIANT == VAR_CH0_AT_START) ? OWNER_A : OWNER_NONE))
    else $error("wrong owner after reset");

  AST_ONE_OWNER: assert property (
    owner != 2'h3)
    else $error("two masters connected");

  AST_FWD_IRQ: assert property (
    (I_CFG[0].fwd_en && !int_n) |=> !O_UPSTREAM_A_IRQ_OUT_N)
    else $error("downstream irq not forwarded to A");

  AST_LOST_FLAG: assert property (
    $fell(owner[1]) |-> flags[1].lost ##1 (!O_UPSTREAM_B_IRQ_OUT_N
      || I_CFG[1].mask_lost))
    else $error("lost flag or irq missing on B");

  AST_MASK_ALL: assert property (
    (!I_CFG[0].fwd_en && I_CFG[0].mask_lost && I_CFG[0].mask_done &&
     I_CFG[0].mask_busy) |=> O_UPSTREAM_A_IRQ_OUT_N)
    else $error("masked irq reached A");

  AST_RECOV_ISOLATE: assert property (
    state == ST_RECOVER |-> owner == OWNER_NONE)
    else $error("master connected during recovery");

  AST_DONE_TARGET: assert property (
    $fell(state == ST_RECOVER) && !$past(|I_REQ) && !$past(|I_DROP) |->
      owner == $past(target) && (flags[0].done == owner[0] ||
      flags[0].done && $past(flags[0].done)))
    else $error("recovery end went to wrong master");

  AST_SENSOR_OFF: assert property (
    (I_SENSOR_DIS || I_RECOV_EN) && O_BUSY_FLAG == 2'h0 |=>
      O_BUSY_FLAG == 2'h0)
    else $error("sensor irq while disabled");

  AST_ISOLATE: assert property (
    !owner[1] |=> !O_UP_SCL_OE[1] && !O_UP_SDA_OE[1])
    else $error("unselected master B driven");

endmodule

// ---- dv/far_side.sv ----
// Far side of the selector: two upstream masters and one downstream
// slave on open-drain lines with pull-ups.
// Assumes the selector's pull-low enables; released lines read high.
`timescale 1ns/1ps
module far_side (
  input  wire logic [1:0] i_up_scl_oe, // Selector pulls master SCL
  input  wire logic [1:0] i_up_sda_oe, // Selector pulls master SDA
  input  wire logic       i_dn_scl_oe, // Selector pulls slave SCL
  input  wire logic       i_dn_sda_oe, // Selector pulls slave SDA
  output logic      [1:0] o_up_scl,    // Master SCL level
  output logic      [1:0] o_up_sda,    // Master SDA level
  output logic            o_dn_scl,    // Slave SCL level
  output logic            o_dn_sda     // Slave SDA level
);
  localparam time HALF = 160ns;
  logic [1:0] m_scl_low = 2'h0;
  logic [1:0] m_sda_low = 2'h0;
  logic       s_scl_low = 1'b0;
  logic       s_sda_low = 1'b0;

  // Pull-ups win once every party lets go
  assign o_up_scl = ~(m_scl_low | i_up_scl_oe);
  assign o_up_sda = ~(m_sda_low | i_up_sda_oe);
  assign o_dn_scl = ~(s_scl_low | i_dn_scl_oe);
  assign o_dn_sda = ~(s_sda_low | i_dn_sda_oe);

  // START, clocks, STOP; SCL stands high outside the frame
  task automatic frame(input int m);
    m_sda_low[m] = 1'b1;
    #HALF;
    repeat (5)
    begin
      m_scl_low[m] = 1'b1;
      #HALF;
      m_scl_low[m] = 1'b0;
      #HALF;
    end
    m_sda_low[m] = 1'b0;
    #HALF;
  endtask

  // Slave side START with no STOP: bus left busy, lines released
  task automatic dn_open();
    s_sda_low = 1'b1;
    #HALF;
    s_scl_low = 1'b1;
    #HALF;
    s_sda_low = 1'b0;
    #HALF;
    s_scl_low = 1'b0;
    #HALF;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Bench for the selector control: all three variants side by side,
// driven by command pulses and the far side model.
// Assumes the package constants and a 25 MHz system clock.
`timescale 1ns/1ps
module tb_top;
  import sel_pkg::*;
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           por_n = 1'b0;
  logic [3:0]     addr = 4'h5;
  logic           int_in_n = 1'b1;
  logic [1:0]     req = 2'h0;
  logic [1:0]     drop = 2'h0;
  logic [1:0]     clr = 2'h0;
  irq_cfg_t [1:0] cfg = '0;
  logic           recov_en = 1'b0;
  logic           sens_dis = 1'b0;
  logic [1:0]     up_scl;
  logic [1:0]     up_sda;
  logic           dn_scl;
  logic           dn_sda;
  logic [1:0]     up_scl_oe [3];
  logic [1:0]     up_sda_oe [3];
  logic           dn_scl_oe [3];
  logic           dn_sda_oe [3];
  logic           irq_a_n [3];
  logic           irq_b_n [3];
  logic [1:0]     lost [3];
  logic [1:0]     done [3];
  logic [1:0]     busy [3];
  logic [1:0]     owner [3];
  logic           recov [3];
  logic [6:0]     saddr [3];
  int             mismatches = 0;
  int             compares = 0;
  int             hits = 0;
  int             rises = 0;
  logic           stop_seen = 1'b0;
  logic           scl_q = 1'b1;
  logic           sda_q = 1'b1;

  always #20 clk = ~clk;

  for (genvar g = 0; g < 3; g++)
  begin : g_var
    master_selector #(.VARIANT(variant_t'(g))) i_dut (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_POR_N(por_n), .I_ADDR(addr),
      .I_UP_SCL(up_scl), .I_UP_SDA(up_sda), .O_UP_SCL(),
      .O_UP_SCL_OE(up_scl_oe[g]), .O_UP_SDA(), .O_UP_SDA_OE(up_sda_oe[g]),
      .I_DN_SCL(dn_scl), .I_DN_SDA(dn_sda), .O_DN_SCL(),
      .O_DN_SCL_OE(dn_scl_oe[g]), .O_DN_SDA(), .O_DN_SDA_OE(dn_sda_oe[g]),
      .I_INT_IN_N(int_in_n), .I_REQ(req), .I_DROP(drop),
      .I_CLR_FLAGS(clr), .I_CFG(cfg), .I_RECOV_EN(recov_en),
      .I_SENSOR_DIS(sens_dis), .O_UPSTREAM_A_IRQ_OUT_N(irq_a_n[g]),
      .O_UPSTREAM_B_IRQ_OUT_N(irq_b_n[g]), .O_OWNERSHIP_LOST_FLAG(lost[g]),
      .O_DONE_FLAG(done[g]), .O_BUSY_FLAG(busy[g]), .O_OWNER(owner[g]),
      .O_RECOV_ACTIVE(recov[g]), .O_SLAVE_ADDR(saddr[g]));
  end

  // Only the first variant's drive reaches the shared lines
  far_side i_far (
    .i_up_scl_oe(up_scl_oe[0]), .i_up_sda_oe(up_sda_oe[0]),
    .i_dn_scl_oe(dn_scl_oe[0]), .i_dn_sda_oe(dn_sda_oe[0]),
    .o_up_scl(up_scl), .o_up_sda(up_sda),
    .o_dn_scl(dn_scl), .o_dn_sda(dn_sda));

  always @(posedge clk)
  begin
    if (dn_sda_oe[0] | dn_scl_oe[0])
      hits++;
    if (recov[0] === 1'b1 && dn_scl && !scl_q)
      rises++;
    if (recov[0] === 1'b1 && dn_scl && scl_q && dn_sda && !sda_q)
      stop_seen = 1'b1;
    scl_q <= dn_scl;
    sda_q <= dn_sda;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Pulse lands on one edge; irq settles one edge after the flags
  task automatic cmd(input logic [1:0] r, input logic [1:0] d,
                     input logic [1:0] c);
    @(negedge clk);
    req = r;
    drop = d;
    clr = c;
    @(negedge clk);
    req = 2'h0;
    drop = 2'h0;
    clr = 2'h0;
    @(negedge clk);
  endtask

  task automatic at_reset(input logic [3:0] straps);
    chk(8'(owner[0]), 8'(OWNER_A));
    chk(8'(owner[1]), 8'(OWNER_NONE));
    chk(8'(owner[2]), 8'(OWNER_NONE));
    chk(8'({lost[0], done[0], busy[0]}), 8'h0);
    chk(8'({irq_a_n[0], irq_b_n[0]}), 8'h3);
    chk(8'(saddr[0]), 8'({ADDR_FIXED, straps}));
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Recovery alone is about 2900 cycles; the rest is far shorter
  initial
  begin
    #(10000 * 40);
    mismatches++;
    complete_run();
  end

  initial
  begin
    wait_cyc(8);
    rst_n = 1'b1;
    por_n = 1'b1;
    @(negedge clk);
    at_reset(4'h5);
    $display("test reset over");
    hits = 0;
    i_far.frame(1);
    wait_cyc(4);
    chk(8'(hits), 8'h0);
    chk(8'(owner[1]), 8'(OWNER_NONE));
    hits = 0;
    i_far.frame(0);
    wait_cyc(4);
    chk(8'(hits > 0), 8'h1);
    chk(8'(owner[1]), 8'(OWNER_A));
    chk(8'(owner[2]), 8'(OWNER_NONE));
    $display("test isolation over");
    i_far.dn_open();
    cmd(2'h2, 2'h0, 2'h0);
    chk(8'(owner[0]), 8'(OWNER_B));
    chk(8'(owner[2]), 8'(OWNER_B));
    chk(8'(lost[0]), 8'h1);
    chk(8'(busy[0]), 8'h2);
    chk(8'({irq_a_n[0], irq_b_n[0]}), 8'h0);
    $display("test takeover over");
    cmd(2'h0, 2'h0, 2'h3);
    cfg = 8'h77;
    sens_dis = 1'b1;
    cmd(2'h1, 2'h0, 2'h0);
    chk(8'(owner[0]), 8'(OWNER_A));
    chk(8'(lost[0]), 8'h2);
    chk(8'(busy[0]), 8'h0);
    chk(8'({irq_a_n[0], irq_b_n[0]}), 8'h3);
    $display("test masks over");
    cfg = 8'h7F;
    int_in_n = 1'b0;
    wait_cyc(6);
    chk(8'({irq_a_n[0], irq_b_n[0]}), 8'h1);
    cfg = 8'hF7;
    wait_cyc(2);
    chk(8'({irq_a_n[0], irq_b_n[0]}), 8'h2);
    int_in_n = 1'b1;
    cfg = 8'h77;
    $display("test forwarding over");
    cmd(2'h0, 2'h2, 2'h0);
    chk(8'(owner[0]), 8'(OWNER_A));
    cmd(2'h0, 2'h1, 2'h0);
    chk(8'(owner[0]), 8'(OWNER_NONE));
    $display("test drop over");
    cmd(2'h0, 2'h0, 2'h3);
    cfg = 8'h00;
    sens_dis = 1'b0;
    recov_en = 1'b1;
    rises = 0;
    stop_seen = 1'b0;
    cmd(2'h2, 2'h0, 2'h0);
    chk(8'(owner[0]), 8'(OWNER_NONE));
    chk(8'(recov[0]), 8'h1);
    for (int n = 0; n < 4000 && owner[0] !== OWNER_B; n++)
      @(negedge clk);
    chk(8'(owner[0]), 8'(OWNER_B));
    // Nine clocks, the NACK clock, then the clock rise of the STOP
    chk(8'(rises), 8'd11);
    chk(8'(stop_seen), 8'h1);
    chk(8'(busy[0]), 8'h0);
    @(negedge clk);
    chk(8'(done[0]), 8'h2);
    chk(8'({irq_a_n[0], irq_b_n[0]}), 8'h2);
    $display("test recovery over");
    recov_en = 1'b0;
    addr = 4'hA;
    por_n = 1'b0;
    wait_cyc(4);
    por_n = 1'b1;
    @(negedge clk);
    at_reset(4'hA);
    cmd(2'h2, 2'h0, 2'h0);
    rst_n = 1'b0;
    wait_cyc(4);
    rst_n = 1'b1;
    @(negedge clk);
    at_reset(4'hA);
    $display("test second reset over");
    complete_run();
  end
endmodule
